// file: rtl/prt_pkg.sv
// types shared by the periodic timer
// assumes: nothing beyond the map header
package prt_pkg;

  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    PRT_MODE_COMPARE = 2'h0,
    PRT_MODE_CAPTURE = 2'h1,
    PRT_MODE_PWM     = 2'h2,
    PRT_MODE_TIMER   = 2'h3
  } prt_mode_t;

  // ==========================================================
  // control register zero layout
  typedef struct packed {
    logic       counter_pause;  // hold count
    logic [2:0] clock_select;   // counter clock source
    logic       counter_enable; // run / stop
    logic [2:0] unused;         // reads zero
  } prt_ctrl0_t;

  // control register one layout
  typedef struct packed {
    prt_mode_t  mode_select;           // operating mode
    logic [1:0] output_function;       // pin action or edge type
    logic       output_initial_level;  // initial level / active level
    logic       output_invert;         // final pin inversion
    logic       capture_source_select; // capture trigger pin
    logic       clear_select;          // clear on a / p match
  } prt_ctrl1_t;

endpackage

// file: rtl/prt_timer.sv
// periodic timer: 10-bit up-counter, comparators a and p, five modes
// assumes: one clock, byte register port, pins are asynchronous inputs
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
`include "prt_timer_map.svh"

// Overview of operation
// - mode 00 is compare match output
// - clear_select low: clear on p, both flags
// - clear_select high: clear on a, a flag only
// - compare a zero: overflow at 3ff, no flag
// - pin changes only on a match per function
// - output function zero: pin never changes
// - enable rise drives pin to initial level
// - mode 11 as compare, pin unused
// - pwm: period clears counter, a sets duty
// - period zero gives 1024 counts
// - duty at or above period is 100 percent
// - pwm raises a and p flags separately
// - pwm level, force and invert controls
// - pwm counter runs while output forced
// - single pulse starts on enable or pin
// - a match or software clear ends pulse
// - single pulse counter resets on enable only
// - capture source and edge select, 11 off
// - capture latches count into compare a
// - capture counter free runs, period clears
// - enable rise zeroes count, fall holds
// - pause holds count, release resumes
module prt_timer #(
  parameter int CNT_W   = 10,
  parameter int TBC_DIV = `PRT_TBC_DIV
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output      logic [7:0] reg_rdata,
  // pins
  input  wire logic       ext_clock_pin,
  input  wire logic       capture_input_pin,
  output      logic       timer_out,
  output      logic       timer_out_used,
  // match flags
  output      logic       match_a_flag,
  output      logic       match_p_flag
);

  // ==========================================================
  // elaboration checks
  localparam int HI_W  = CNT_W - 8;
  localparam int TBC_W = (TBC_DIV > 2) ? $clog2(TBC_DIV) : 1;

  // high byte must hold the bits above eight
  if (CNT_W < 9 || CNT_W > 16) begin : g_bad_width
    $error("counter width must be 9 to 16");
  end
  if (TBC_DIV < 2) begin : g_bad_tbc
    $error("time base divide must be at least 2");
  end

  // ==========================================================
  // functions
  // address hit for a strobe
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // high part of a count, zero padded to a byte
  function automatic logic [7:0] hi_byte(input logic [CNT_W-1:0] v);
    hi_byte = {{(16 - CNT_W){1'b0}}, v[CNT_W-1:8]};
  endfunction

  // ==========================================================
  // state
  prt_pkg::prt_ctrl0_t ctrl0_ff;           // pause, clock, enable
  prt_pkg::prt_ctrl1_t ctrl1_ff;           // mode and pin setup
  logic [CNT_W-1:0]    cnt_ff;             // the counter
  logic [CNT_W-1:0]    cmpa_ff;            // compare_a_value
  logic [CNT_W-1:0]    per_ff;             // period_value
  logic                flag_a_ff;          // match_a_flag
  logic                flag_p_ff;          // match_p_flag
  logic                en_prev_ff;         // enable one cycle ago
  logic                lvl_ff;             // compare output level
  logic                pin_ff;             // driven pin level
  logic                used_ff;            // pin owned by timer
  logic [7:0]          rdata_ff;           // read answer
  logic [5:0]          pre_ff;             // system prescaler
  logic [TBC_W-1:0]    tbc_ff;             // time base prescaler
  logic [2:0]          ext_sync_ff;        // ext clock pin sync
  logic                ext_f_ff;           // ext pin settled level
  logic                ext_prev_ff;        // ext level last cycle
  logic [2:0]          cap_sync_ff;        // capture pin sync
  logic                cap_f_ff;           // capture settled level
  logic                cap_prev_ff;        // capture level last cycle

  // ==========================================================
  // register decode
  wire wr_ctrl0 = reg_wr && hit(reg_addr, `PRT_OFS_CTRL0);
  wire wr_ctrl1 = reg_wr && hit(reg_addr, `PRT_OFS_CTRL1);
  wire wr_cmpl  = reg_wr && hit(reg_addr, `PRT_OFS_CMPA_LO);
  wire wr_cmph  = reg_wr && hit(reg_addr, `PRT_OFS_CMPA_HI);
  wire wr_perl  = reg_wr && hit(reg_addr, `PRT_OFS_PER_LO);
  wire wr_perh  = reg_wr && hit(reg_addr, `PRT_OFS_PER_HI);
  wire wr_flags = reg_wr && hit(reg_addr, `PRT_OFS_FLAGS);

  // ==========================================================
  // mode decode
  wire prt_pkg::prt_mode_t mode = ctrl1_ff.mode_select;
  wire [1:0] ofn    = ctrl1_ff.output_function;
  wire       oc     = ctrl1_ff.output_initial_level;
  wire       pol    = ctrl1_ff.output_invert;
  wire       is_cmp = (mode == prt_pkg::PRT_MODE_COMPARE) ||
                      (mode == prt_pkg::PRT_MODE_TIMER);
  wire       is_ps  = (mode == prt_pkg::PRT_MODE_PWM);
  wire       is_sp  = is_ps && (ofn == 2'h3);
  wire       is_pwm = is_ps && (ofn != 2'h3);
  wire       is_cap = (mode == prt_pkg::PRT_MODE_CAPTURE);

  // ==========================================================
  // pin edges from the settled levels
  wire ext_rise = ext_f_ff && !ext_prev_ff;
  wire ext_fall = !ext_f_ff && ext_prev_ff;
  wire cap_rise = cap_f_ff && !cap_prev_ff;
  wire cap_fall = !cap_f_ff && cap_prev_ff;

  // ==========================================================
  // counter clock enable
  wire [2:0] csel     = ctrl0_ff.clock_select;
  wire       t_sys4   = (pre_ff[1:0] == 2'(`PRT_SYS4_DIV - 1));
  wire       t_fh16   = (pre_ff[3:0] == 4'(`PRT_FH16_DIV - 1));
  wire       t_fh64   = (pre_ff == 6'(`PRT_FH64_DIV - 1));
  wire       t_tbc    = (tbc_ff == TBC_W'(TBC_DIV - 1));
  wire       src_tick = (csel == 3'h0) ? t_sys4 :
                        (csel == 3'h1) ? 1'b1 :
                        (csel == 3'h2) ? t_fh16 :
                        (csel == 3'h3) ? t_fh64 :
                        (csel == 3'h6) ? ext_rise :
                        (csel == 3'h7) ? ext_fall : t_tbc;

  // ==========================================================
  // run control and comparators
  wire             en      = ctrl0_ff.counter_enable;
  wire             en_rise = en && !en_prev_ff;
  // rise cycle only zeroes, pause freezes the count
  wire             tick    = en && !en_rise &&
                             !ctrl0_ff.counter_pause && src_tick;
  wire [CNT_W-1:0] cnt_inc = CNT_W'(cnt_ff + 1'b1);
  // period match on the count reaching the period, zero wraps at max
  wire             p_hit   = tick && (cnt_inc == per_ff);
  // compare modes never match a zero compare value
  wire             a_hit   = tick && !is_cap && (cnt_inc == cmpa_ff) &&
                             ((cmpa_ff != '0) || !is_cmp);

  // ==========================================================
  // capture trigger
  wire trg_rise = ctrl1_ff.capture_source_select ? ext_rise : cap_rise;
  wire trg_fall = ctrl1_ff.capture_source_select ? ext_fall : cap_fall;
  wire cap_edge = (ofn == 2'h0) ? trg_rise :
                  (ofn == 2'h1) ? trg_fall :
                  (ofn == 2'h2) ? (trg_rise || trg_fall) : 1'b0;
  wire cap_evt  = is_cap && en && cap_edge;

  // ==========================================================
  // counter clear and flag events
  wire clr_cnt = is_cmp ? (ctrl1_ff.clear_select ? a_hit : p_hit) :
                 (is_pwm || is_cap) ? p_hit : 1'b0;
  wire set_a   = is_cap ? cap_evt : a_hit;
  wire set_p   = is_cmp ? (p_hit && !ctrl1_ff.clear_select) :
                 (is_pwm || is_cap) ? p_hit : 1'b0;

  // ==========================================================
  // next counter value
  wire [CNT_W-1:0] nxt_cnt = en_rise ? '0 :
                             !tick   ? cnt_ff :
                             clr_cnt ? '0 : cnt_inc;

  // compare a: a capture outranks a software write
  wire [CNT_W-1:0] cmpa_sw = {wr_cmph ? reg_wdata[HI_W-1:0] : cmpa_ff[CNT_W-1:8],
                              wr_cmpl ? reg_wdata : cmpa_ff[7:0]};
  wire [CNT_W-1:0] nxt_cmpa = cap_evt ? cnt_ff : cmpa_sw;
  wire [CNT_W-1:0] nxt_per  = {wr_perh ? reg_wdata[HI_W-1:0] : per_ff[CNT_W-1:8],
                               wr_perl ? reg_wdata : per_ff[7:0]};

  // ==========================================================
  // control zero with hardware enable set and clear
  wire [7:0] ctrl0_sw  = wr_ctrl0 ? (reg_wdata & `PRT_CTRL0_MASK) : ctrl0_ff;
  wire       ext_act   = (csel == 3'h7) ? ext_fall : ext_rise;
  wire       sp_start  = is_sp && !en && ext_act;
  wire       sp_end    = is_sp && a_hit;
  wire       nxt_en    = sp_start ? 1'b1 : sp_end ? 1'b0 : ctrl0_sw[3];
  wire [7:0] nxt_ctrl0 = {ctrl0_sw[7:4], nxt_en, 3'h0};

  // ==========================================================
  // match flags, a new event beats a clear in the same cycle
  wire nxt_flag_a = set_a ||
                    (flag_a_ff && !(wr_flags && reg_wdata[`PRT_FLAG_A_BIT]));
  wire nxt_flag_p = set_p ||
                    (flag_p_ff && !(wr_flags && reg_wdata[`PRT_FLAG_P_BIT]));

  // ==========================================================
  // compare output level
  wire lvl_act = (ofn == 2'h1) ? 1'b0 :
                 (ofn == 2'h2) ? 1'b1 : !lvl_ff;
  wire nxt_lvl = en_rise ? oc :
                 (is_cmp && a_hit && (ofn != 2'h0)) ? lvl_act :
                 lvl_ff;

  // ==========================================================
  // pwm and single pulse levels
  wire [CNT_W:0] per_len = (per_ff == '0) ? (CNT_W + 1)'(1 << CNT_W)
                                          : {1'b0, per_ff};
  // duty at or above the period stays active all period
  wire pwm_act = ({1'b0, cnt_ff} < {1'b0, cmpa_ff}) ||
                 ({1'b0, cmpa_ff} >= per_len);
  wire pwm_lvl = (ofn == 2'h2) ? (pwm_act ? oc : !oc) :
                 (ofn == 2'h1) ? oc : !oc;
  wire sp_lvl  = nxt_en ? oc : !oc;

  // ==========================================================
  // pin drive, timer and capture modes leave the pin idle low
  wire nxt_pin  = (mode == prt_pkg::PRT_MODE_COMPARE) ? (nxt_lvl ^ pol) :
                  is_sp  ? (sp_lvl ^ pol) :
                  is_pwm ? (pwm_lvl ^ pol) : 1'b0;
  wire nxt_used = (mode == prt_pkg::PRT_MODE_COMPARE) || is_ps;

  // ==========================================================
  // read mux, unmapped offsets answer zero
  wire [7:0] rd_mux =
    hit(reg_addr, `PRT_OFS_CTRL0)   ? ctrl0_ff :
    hit(reg_addr, `PRT_OFS_CTRL1)   ? ctrl1_ff :
    hit(reg_addr, `PRT_OFS_CNT_LO)  ? cnt_ff[7:0] :
    hit(reg_addr, `PRT_OFS_CNT_HI)  ? hi_byte(cnt_ff) :
    hit(reg_addr, `PRT_OFS_CMPA_LO) ? cmpa_ff[7:0] :
    hit(reg_addr, `PRT_OFS_CMPA_HI) ? hi_byte(cmpa_ff) :
    hit(reg_addr, `PRT_OFS_PER_LO)  ? per_ff[7:0] :
    hit(reg_addr, `PRT_OFS_PER_HI)  ? hi_byte(per_ff) :
    hit(reg_addr, `PRT_OFS_FLAGS)   ? {6'h00, flag_p_ff, flag_a_ff} :
    `PRT_RST_BYTE;
  // data stand only in the cycle after the strobe
  wire [7:0] nxt_rdata = reg_rd ? rd_mux : 8'h00;

  // ==========================================================
  // pin synchronisers, a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_sync_ff <= 3'h0;
      cap_sync_ff <= 3'h0;
      ext_f_ff    <= 1'b0;
      cap_f_ff    <= 1'b0;
      ext_prev_ff <= 1'b0;
      cap_prev_ff <= 1'b0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], ext_clock_pin};
      cap_sync_ff <= {cap_sync_ff[1:0], capture_input_pin};
      // stage one feeds stage two only
      if (ext_sync_ff[1] == ext_sync_ff[2]) begin
        ext_f_ff <= ext_sync_ff[2];
      end
      if (cap_sync_ff[1] == cap_sync_ff[2]) begin
        cap_f_ff <= cap_sync_ff[2];
      end
      ext_prev_ff <= ext_f_ff;
      cap_prev_ff <= cap_f_ff;
    end
  end

  // ==========================================================
  // prescalers, free running so the tick rate is independent of enable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pre_ff <= 6'h00;
      tbc_ff <= '0;
    end else begin
      pre_ff <= 6'(pre_ff + 1'b1);
      tbc_ff <= t_tbc ? '0 : TBC_W'(tbc_ff + 1'b1);
    end
  end

  // ==========================================================
  // registers and counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl0_ff   <= `PRT_RST_BYTE;
      ctrl1_ff   <= `PRT_RST_BYTE;
      cnt_ff     <= '0;
      cmpa_ff    <= '0;
      per_ff     <= '0;
      flag_a_ff  <= 1'b0;
      flag_p_ff  <= 1'b0;
      en_prev_ff <= 1'b0;
    end else begin
      ctrl0_ff   <= nxt_ctrl0;
      if (wr_ctrl1) begin
        ctrl1_ff <= reg_wdata;
      end
      cnt_ff     <= nxt_cnt;
      cmpa_ff    <= nxt_cmpa;
      per_ff     <= nxt_per;
      flag_a_ff  <= nxt_flag_a;
      flag_p_ff  <= nxt_flag_p;
      en_prev_ff <= en;
    end
  end

  // ==========================================================
  // output flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lvl_ff   <= 1'b0;
      pin_ff   <= 1'b0;
      used_ff  <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      lvl_ff   <= nxt_lvl;
      pin_ff   <= nxt_pin;
      used_ff  <= nxt_used;
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // port drive, each straight from a flop
  assign reg_rdata      = rdata_ff;
  assign timer_out      = pin_ff;
  assign timer_out_used = used_ff;
  assign match_a_flag   = flag_a_ff;
  assign match_p_flag   = flag_p_ff;

endmodule

// file: rtl/prt_timer_map.svh
// register offsets, field positions, reset values and divider counts
// assumes: included by bare name from the timer module
`ifndef PRT_TIMER_MAP_SVH
`define PRT_TIMER_MAP_SVH

// ==========================================================
// register offsets on the byte register port
`define PRT_OFS_CTRL0   4'h0
`define PRT_OFS_CTRL1   4'h1
`define PRT_OFS_CNT_LO  4'h2
`define PRT_OFS_CNT_HI  4'h3
`define PRT_OFS_CMPA_LO 4'h4
`define PRT_OFS_CMPA_HI 4'h5
`define PRT_OFS_PER_LO  4'h6
`define PRT_OFS_PER_HI  4'h7
`define PRT_OFS_FLAGS   4'h8

// ==========================================================
// field positions and reset values
`define PRT_FLAG_A_BIT  0
`define PRT_FLAG_P_BIT  1
`define PRT_CTRL0_MASK  8'hf8
`define PRT_RST_BYTE    8'h00

// ==========================================================
// prescaler divide counts for the counter clock choices
`define PRT_SYS4_DIV    4
`define PRT_FH16_DIV    16
`define PRT_FH64_DIV    64
`define PRT_TBC_DIV     256

`endif

// file: tb/prt_pin_model.sv
// outside world at the timer pins: trigger and capture sources
// assumes: bench calls pin_set just after a rising clock edge
`timescale 1ns/1ns
module prt_pin_model (
  // clock
  input wire logic mclk,
  // pins toward the timer
  output     logic ext_clock_pin,
  output     logic capture_input_pin
);
  // both pins idle low until pin_set drives one of them
  initial begin
    ext_clock_pin     = 1'b0;
    capture_input_pin = 1'b0;
  end
  // one level change, then held past the synchroniser depth
  task automatic pin_set(input bit sel, input bit lvl);
    @(posedge mclk);
    if (sel) ext_clock_pin <= lvl;
    else capture_input_pin <= lvl;
    repeat (6) @(posedge mclk);
  endtask
endmodule

// file: tb/prt_timer_asserts.sv
// checker for the periodic timer: pin and flag timing seen at the ports
// assumes: bound to prt_timer; flags clear by writing ones at offset 8
`timescale 1ns/1ns
module prt_timer_asserts (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and flags
  input wire logic       ext_clock_pin,
  input wire logic       capture_input_pin,
  input wire logic       timer_out,
  input wire logic       timer_out_used,
  input wire logic       match_a_flag,
  input wire logic       match_p_flag
);
  // ==========================================================
  // shadow of the control writes and a quiet-time counter
  logic [7:0] c1_ff;    // last value written to ctrl1
  logic       en_ff;    // enable as last written; stale after auto clears
  logic [2:0] quiet_ff; // cycles since a control write, saturating
  wire        ctl_wr = reg_wr && reg_addr[3:1] == 3'h0;    // ctrl0 or ctrl1
  wire        clr_a  = reg_wr && reg_addr == 4'h8 && reg_wdata[0];
  wire        clr_p  = reg_wr && reg_addr == 4'h8 && reg_wdata[1];
  wire        quiet  = quiet_ff == 3'h7;                    // pipeline settled
  wire        cmp_md = c1_ff[7:6] == 2'h0;                  // compare mode
  // shadow registers follow the write strobe only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      c1_ff    <= 8'h00;
      en_ff    <= 1'b0;
      quiet_ff <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == 4'h1) c1_ff <= reg_wdata;
      if (reg_wr && reg_addr == 4'h0) en_ff <= reg_wdata[3];
      quiet_ff <= ctl_wr ? 3'h0 : (quiet ? quiet_ff : quiet_ff + 3'h1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // enable rise in compare mode, output not inverted
  sequence s_en_rise;
    reg_wr && reg_addr == 4'h0 && reg_wdata[3] && !en_ff && cmp_md && !c1_ff[2];
  endsequence
  chk_en_level: assert property (s_en_rise |-> ##[1:4] timer_out == c1_ff[3])
    else $error("pin not at initial level after enable rise");
  chk_a_sticky: assert property ($past(match_a_flag) && !$past(clr_a) |-> match_a_flag)
    else $error("a flag dropped without a clear");
  chk_p_sticky: assert property ($past(match_p_flag) && !$past(clr_p) |-> match_p_flag)
    else $error("p flag dropped without a clear");
  chk_pin_unused: assert property (quiet && c1_ff[7:6] == 2'h3 |-> !timer_out_used && !timer_out)
    else $error("pin used in timer mode");
  chk_no_change: assert property (quiet && cmp_md && c1_ff[5:4] == 2'h0 |-> $stable(timer_out))
    else $error("pin moved with output function zero");
  chk_pin_on_a: assert property (quiet && cmp_md && !$stable(timer_out) |-> match_a_flag || $past(match_a_flag))
    else $error("pin moved without an a match");
  chk_no_p_flag: assert property (quiet && cmp_md && c1_ff[0] |-> !$rose(match_p_flag))
    else $error("p flag raised while clearing on a");
  chk_cap_off: assert property (quiet && c1_ff[7:4] == 4'h7 |-> !$rose(match_a_flag))
    else $error("capture flag raised while capture disabled");
endmodule

bind prt_timer prt_timer_asserts i_chk (
  .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_clock_pin(ext_clock_pin), .capture_input_pin(capture_input_pin),
  .timer_out(timer_out), .timer_out_used(timer_out_used),
  .match_a_flag(match_a_flag), .match_p_flag(match_p_flag)
);

// file: tb/prt_timer_bench.sv
// self-checking bench for the periodic timer
// assumes: prt_timer, its checker bind and the pin model are compiled
`timescale 1ns/1ns
module prt_timer_bench;
  // ==========================================================
  // design signals and counters
  logic       mclk;
  logic       rstn;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       ext_clock_pin;
  logic       capture_input_pin;
  logic       timer_out;
  logic       timer_out_used;
  logic       match_a_flag;
  logic       match_p_flag;
  int         n_errors;
  int         checks;
  int         seed;
  // pwm table: ctrl1, period, duty, expected high counts per period
  logic [7:0] pc[8] = '{8'ha8, 8'ha8, 8'ha8, 8'hac, 8'ha0, 8'h88, 8'h98, 8'ha8};
  int         pp[8] = '{8, 8, 8, 8, 8, 8, 8, 0};
  int         pd[8] = '{3, 8, 12, 3, 3, 3, 3, 0};
  int         pe[8] = '{3, 8, 8, 5, 5, 0, 8, 0};
  logic [7:0] cm[2] = '{8'h01, 8'hf1};

  always #50 mclk = ~mclk;

  // small prescaler value keeps the slow clock choice short
  prt_timer #(.TBC_DIV(4)) i_prt_timer (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_clock_pin(ext_clock_pin), .capture_input_pin(capture_input_pin),
    .timer_out(timer_out), .timer_out_used(timer_out_used),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag)
  );
  prt_pin_model i_pins (
    .mclk(mclk), .ext_clock_pin(ext_clock_pin), .capture_input_pin(capture_input_pin)
  );

  // ==========================================================
  // comparison, bus and measuring tasks
  task automatic print_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // write then one idle cycle, so strobes never collide
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic cfg(input logic [7:0] c1, input int a, input int p,
                     input logic [7:0] c0);
    wr(4'h0, 8'h00);
    wr(4'h1, c1);
    wr(4'h4, a[7:0]);
    wr(4'h5, {6'h00, a[9:8]});
    wr(4'h6, p[7:0]);
    wr(4'h7, {6'h00, p[9:8]});
    wr(4'h0, c0);
  endtask
  // bounded wait for a flag; n is cycles waited
  task automatic wflag(input int s, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((s ? match_p_flag : match_a_flag) !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      n_errors++;
      print_verdict();
    end
    @(posedge mclk);
  endtask
  // spacing of two successive flag raises; clear write costs two cycles
  // first wait may end late when a raise meets the clear, so it only aligns
  task automatic per(input int s, output int p);
    int n;
    wr(4'h8, 8'h03);
    wflag(s, n);
    repeat (2) begin
      wr(4'h8, 8'h03);
      wflag(s, n);
    end
    p = n + 2;
  endtask
  task automatic hi_cnt(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(negedge mclk);
      h += (timer_out === 1'b1);
    end
    @(posedge mclk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    int v, h, p;
    logic [7:0] r, r2;
    mclk = 1'b0; rstn = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; n_errors = 0; checks = 0; seed = 94473;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    // reset values, unused high bits, unmapped offset
    for (int a = 4; a < 8; a++) begin
      rd(a[3:0], r);
      chk(r, 8'h00);
    end
    for (int a = 5; a < 10; a++) begin
      wr(a[3:0], 8'hff);
      rd(a[3:0], r);
      chk(r, a == 6 ? 8'hff : (a > 7 ? 8'h00 : 8'h03));
    end
    $display("test registers done");
    // compare mode, clear on p, toggle output
    p = 4 + ($random(seed) & 7);
    cfg(8'h30, p - 1, p, 8'h18);
    @(negedge mclk);
    chk(timer_out, 1'b0);
    @(posedge mclk);
    per(1, v);
    chk(v, p);
    per(0, v);
    chk(v, p);
    hi_cnt(4 * p, h);
    chk(h, 2 * p);
    // clear on a with period below compare a, compare and timer modes
    foreach (cm[i]) begin
      cfg(cm[i], 7, 3, 8'h18);
      per(0, v);
      chk(v, 7);
      @(negedge mclk);
      chk(match_p_flag, 1'b0);
      chk(timer_out_used, i == 0);
      chk(timer_out, 1'b0);
      @(posedge mclk);
    end
    // compare a zero: overflow only, never an a flag; initial level high
    cfg(8'h09, 0, 0, 8'h18);
    wr(4'h8, 8'h03);
    repeat (1100) @(posedge mclk);
    @(negedge mclk);
    chk(match_a_flag, 1'b0);
    chk(timer_out, 1'b1);
    @(posedge mclk);
    $display("test compare done");
    // pwm rows, last one random
    pp[7] = 5 + ($random(seed) & 15);
    pd[7] = pp[7] - 2;
    pe[7] = pd[7];
    for (int i = 0; i < 8; i++) begin
      cfg(pc[i], pd[i], pp[i], 8'h18);
      repeat (2 * pp[i]) @(posedge mclk);
      hi_cnt(4 * pp[i], h);
      chk(h, 4 * pe[i]);
      per(1, v);
      chk(v, pp[i]);
    end
    per(0, v);
    chk(v, pp[7]);
    cfg(8'ha8, 5, 0, 8'h18);
    per(1, v);
    chk(v, 1024);
    $display("test pwm done");
    // single pulse started by the trigger pin
    cfg(8'hb8, 6, 0, 8'h10);
    wr(4'h8, 8'h03);
    fork
      i_pins.pin_set(1, 1);
      hi_cnt(40, h);
    join
    chk(h, 7);
    chk(match_a_flag, 1'b1);
    rd(4'h0, r);
    chk(r[3], 1'b0);
    i_pins.pin_set(1, 0);
    $display("test single pulse done");
    // capture on the input pin, then disabled, then both edges on the clock pin
    cfg(8'h40, 0, 0, 8'h18);
    wr(4'h8, 8'h03);
    repeat (20) @(posedge mclk);
    i_pins.pin_set(0, 1);
    chk(match_a_flag, 1'b1);
    rd(4'h4, r);
    rd(4'h5, r2);
    v = {r2[1:0], r};
    chk(v >= 20 && v <= 40, 1'b1);
    cfg(8'h70, 0, 0, 8'h18);
    wr(4'h8, 8'h03);
    i_pins.pin_set(0, 0);
    chk(match_a_flag, 1'b0);
    cfg(8'h62, 0, 0, 8'h18);
    wr(4'h8, 8'h03);
    i_pins.pin_set(1, 1);
    chk(match_a_flag, 1'b1);
    wr(4'h8, 8'h03);
    i_pins.pin_set(1, 0);
    chk(match_a_flag, 1'b1);
    // falling edge only on the capture pin
    cfg(8'h50, 0, 0, 8'h18);
    wr(4'h8, 8'h03);
    i_pins.pin_set(0, 1);
    chk(match_a_flag, 1'b0);
    i_pins.pin_set(0, 0);
    chk(match_a_flag, 1'b1);
    $display("test capture done");
    // stop keeps the count, rise zeroes it, pause holds and resumes
    wr(4'h0, 8'h10);
    rd(4'h2, r);
    repeat (5) @(posedge mclk);
    rd(4'h2, r2);
    chk(r2, r);
    wr(4'h0, 8'h18);
    rd(4'h2, r);
    chk(r < 8'h08, 1'b1);
    wr(4'h0, 8'h98);
    rd(4'h2, r);
    repeat (5) @(posedge mclk);
    rd(4'h2, r2);
    chk(r2, r);
    wr(4'h0, 8'h18);
    rd(4'h2, r2);
    chk(r2 > r, 1'b1);
    $display("test counter control done");
    print_verdict();
  end
endmodule
